/* File: rtl/prpi_panel.sv */
`timescale 1ns/1ps
module prpi_panel (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	prpi_link_if.panel                      link,
	output logic                            pix_valid,
	output logic [prpi_pkg::X_W-1:0]        pix_x,
	output logic [prpi_pkg::Y_W-1:0]        pix_y,
	output logic [prpi_pkg::PIX_W-1:0]      pix_rgb,
	output logic                            line_start,
	output logic                            frame_start,
	output logic                            default_pos,
	output logic                            enable_fault
);
	localparam int CW = prpi_pkg::CNT_W;
	localparam int XW = prpi_pkg::X_W;
	localparam int YW = prpi_pkg::Y_W;
	localparam logic [XW-1:0] X_LAST = XW'(prpi_pkg::H_ACTIVE - 1);
	localparam logic [YW-1:0] Y_LAST = YW'(prpi_pkg::V_ACTIVE - 1);
	localparam logic [CW-1:0] XA     = CW'(prpi_pkg::H_ACTIVE);
	localparam logic [CW-1:0] YA     = CW'(prpi_pkg::V_ACTIVE);
	localparam logic [CW-1:0] HA0    = CW'(prpi_pkg::H_START);
	localparam logic [CW-1:0] HA1    = CW'(prpi_pkg::H_START + prpi_pkg::H_ACTIVE);
	localparam logic [CW-1:0] VA0    = CW'(prpi_pkg::V_START);
	localparam logic [CW-1:0] VA1    = CW'(prpi_pkg::V_START + prpi_pkg::V_ACTIVE);
	localparam logic [CW-1:0] CNT_MAX = '1;

	logic                  pclk_prev_r;
	logic                  hs_prev_r;
	logic                  vs_prev_r;
	logic                  de_prev_r;
	logic [CW-1:0]         hcnt_r;
	logic [CW-1:0]         vcnt_r;
	logic [CW-1:0]         xcnt_r;
	logic [CW-1:0]         yde_r;
	logic                  de_in_frame_r;
	prpi_pkg::prpi_hpos_t  hpos_r;

	// Only the rising pixel clock edge samples the bus
	wire tick       = link.pixel_sample_clock & ~pclk_prev_r;
	wire de         = link.pixel_valid_window;
	wire line_go    = tick & hs_prev_r & ~link.hsync_n;
	wire frame_go   = tick & vs_prev_r & ~link.vsync_n;
	wire de_rise    = tick & de & ~de_prev_r;
	wire de_fall    = tick & ~de & de_prev_r;
	// The enable rise positions its own pixel, not only the ones after it
	wire by_enable  = (hpos_r == prpi_pkg::PRPI_POS_ENABLE) | de_rise;

	// Enable-positioned pixel: counts from the enable rise, capped at one line
	wire [CW-1:0] x_en   = de_rise ? prpi_pkg::CNT_ZERO : xcnt_r;
	wire          en_act = de & (x_en < XA) & (yde_r < YA);
	wire          en_over = tick & de & ~de_rise & (xcnt_r >= XA);
	// Built-in position: fixed window after the syncs
	wire          df_act = (hcnt_r >= HA0) && (hcnt_r < HA1) &&
	                       (vcnt_r >= VA0) && (vcnt_r < VA1);
	wire [CW-1:0] x_df   = hcnt_r - HA0;
	wire [CW-1:0] y_df   = vcnt_r - VA0;

	wire          act    = tick & (by_enable ? en_act : df_act);
	wire [XW-1:0] x_raw  = by_enable ? x_en[XW-1:0] : x_df[XW-1:0];
	wire [YW-1:0] y_raw  = by_enable ? yde_r[YW-1:0] : y_df[YW-1:0];
	wire [XW-1:0] x_scan = link.scan_rightward ? x_raw : X_LAST - x_raw;
	wire [YW-1:0] y_scan = link.scan_downward ? y_raw : Y_LAST - y_raw;
	wire [prpi_pkg::PIX_W-1:0] rgb_bus = {link.red_component_bus,
	                                      link.green_component_bus,
	                                      link.blue_component_bus};

	// Position source: any enable rise selects it; a whole frame with the enable low drops it
	wire frame_no_de = frame_go & ~de_in_frame_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pclk_prev_r <= 1'b0;
			hs_prev_r   <= 1'b1;
			vs_prev_r   <= 1'b1;
			de_prev_r   <= 1'b0;
		end else begin
			pclk_prev_r <= link.pixel_sample_clock;
			if (tick) begin
				hs_prev_r <= link.hsync_n;
				vs_prev_r <= link.vsync_n;
				de_prev_r <= de;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hcnt_r <= CNT_MAX;
			vcnt_r <= CNT_MAX;
		end else begin
			// The sync-fall pixel is position 0, so the next sampled one is 1
			if (line_go)
				hcnt_r <= CW'(1);
			else if (tick && hcnt_r != CNT_MAX)
				hcnt_r <= hcnt_r + 1'b1;
			if (frame_go)
				vcnt_r <= prpi_pkg::CNT_ZERO;
			else if (line_go && vcnt_r != CNT_MAX)
				vcnt_r <= vcnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			xcnt_r <= CNT_MAX;
			yde_r  <= prpi_pkg::CNT_ZERO;
		end else begin
			if (de_rise)
				xcnt_r <= CW'(1);
			else if (tick && de && xcnt_r != CNT_MAX)
				xcnt_r <= xcnt_r + 1'b1;
			if (frame_go)
				yde_r <= prpi_pkg::CNT_ZERO;
			else if (de_fall && yde_r != CNT_MAX)
				yde_r <= yde_r + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hpos_r        <= prpi_pkg::PRPI_POS_DEFAULT;
			de_in_frame_r <= 1'b0;
		end else begin
			if (de_rise)
				hpos_r <= prpi_pkg::PRPI_POS_ENABLE;
			else if (frame_no_de)
				hpos_r <= prpi_pkg::PRPI_POS_DEFAULT;
			// A sampled high enable wins over the frame-start clear
			if (tick && de)
				de_in_frame_r <= 1'b1;
			else if (frame_go)
				de_in_frame_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pix_valid    <= 1'b0;
			pix_x        <= '0;
			pix_y        <= '0;
			pix_rgb      <= '0;
			line_start   <= 1'b0;
			frame_start  <= 1'b0;
			default_pos  <= 1'b1;
			enable_fault <= 1'b0;
		end else begin
			pix_valid   <= act;
			line_start  <= line_go;
			frame_start <= frame_go;
			default_pos <= ~by_enable;
			if (act) begin
				pix_x   <= x_scan;
				pix_y   <= y_scan;
				pix_rgb <= rgb_bus;
			end
			// Sticky; set wins over the clear at the next frame start
			if (en_over)
				enable_fault <= 1'b1;
			else if (frame_go)
				enable_fault <= 1'b0;
		end
	end
endmodule : prpi_panel

/* File: inc/prpi_pkg.sv */
package prpi_pkg;
	localparam int COMP_W         = 6;
	localparam int PIX_W          = 3 * COMP_W;
	localparam int R_LSB          = 2 * COMP_W;
	localparam int G_LSB          = COMP_W;
	localparam int B_LSB          = 0;
	localparam int H_ACTIVE       = 640;
	localparam int V_ACTIVE       = 480;
	localparam int X_W            = 10;
	localparam int Y_W            = 9;
	localparam int CNT_W          = 10;
	// 750 x 515 at 20 MHz pixel rate keeps the refresh above 50 Hz
	localparam int H_TOTAL        = 750;
	localparam int H_SYNC         = 96;
	localparam int H_START        = 104;
	localparam int V_TOTAL        = 515;
	localparam int V_SYNC         = 2;
	localparam int V_START        = 34;
	localparam int CLK_PERIOD_NS  = 25;
	localparam int PIX_DIV        = 2;
	localparam int MIN_FRAME_HZ   = 50;
	localparam int MAX_FRAME_NS   = 1000000000 / MIN_FRAME_HZ;
	localparam int FRAME_CYCLES   = H_TOTAL * V_TOTAL * PIX_DIV;
	localparam int FIFO_DEPTH     = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
	typedef enum logic {PRPI_POS_DEFAULT, PRPI_POS_ENABLE} prpi_hpos_t;
endpackage : prpi_pkg

/* File: inc/prpi_link_if.sv */
`timescale 1ns/1ps
interface prpi_link_if;
	logic                            pixel_sample_clock;
	logic                            hsync_n;
	logic                            vsync_n;
	logic                            pixel_valid_window;
	logic [prpi_pkg::COMP_W-1:0]     red_component_bus;
	logic [prpi_pkg::COMP_W-1:0]     green_component_bus;
	logic [prpi_pkg::COMP_W-1:0]     blue_component_bus;
	logic                            scan_rightward;
	logic                            scan_downward;

	modport ctrl (
		output pixel_sample_clock,
		output hsync_n,
		output vsync_n,
		output pixel_valid_window,
		output red_component_bus,
		output green_component_bus,
		output blue_component_bus,
		output scan_rightward,
		output scan_downward
	);

	modport panel (
		input pixel_sample_clock,
		input hsync_n,
		input vsync_n,
		input pixel_valid_window,
		input red_component_bus,
		input green_component_bus,
		input blue_component_bus,
		input scan_rightward,
		input scan_downward
	);
endinterface : prpi_link_if

/* File: rtl/prpi_ctrl.sv */
`timescale 1ns/1ps
module prpi_fifo #(
	parameter int W     = 18,
	parameter int DEPTH = 8
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	// Pointer wrap relies on a power-of-two depth
	if (W < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("prpi_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   count_r;
	logic [AW:0]   count_nxt;
	wire           push = in_valid & in_ready;
	wire           pop  = out_valid & out_ready;

	assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rd_ptr_r];

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			in_ready <= 1'b0;
		end else begin
			wr_ptr_r <= wr_ptr_r + AW'(push);
			rd_ptr_r <= rd_ptr_r + AW'(pop);
			count_r  <= count_nxt;
			in_ready <= (count_nxt != FULL);
		end
	end
endmodule : prpi_fifo

module prpi_ctrl #(
	parameter int DEPTH = prpi_pkg::FIFO_DEPTH
) (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	prpi_link_if.ctrl                       link,
	input  wire logic                       pix_in_valid,
	output logic                            pix_in_ready,
	input  wire logic [prpi_pkg::PIX_W-1:0] pix_in_data,
	input  wire logic                       use_enable,
	input  wire logic                       mirror_h,
	input  wire logic                       flip_v,
	output logic                            frame_tick,
	output logic                            underrun
);
	localparam int CW = prpi_pkg::CNT_W;
	localparam int PW = prpi_pkg::PIX_W;
	localparam logic [CW-1:0] HT  = CW'(prpi_pkg::H_TOTAL - 1);
	localparam logic [CW-1:0] VT  = CW'(prpi_pkg::V_TOTAL - 1);
	localparam logic [CW-1:0] HS  = CW'(prpi_pkg::H_SYNC);
	localparam logic [CW-1:0] VS  = CW'(prpi_pkg::V_SYNC);
	localparam logic [CW-1:0] HA0 = CW'(prpi_pkg::H_START);
	localparam logic [CW-1:0] HA1 = CW'(prpi_pkg::H_START + prpi_pkg::H_ACTIVE);
	localparam logic [CW-1:0] VA0 = CW'(prpi_pkg::V_START);
	localparam logic [CW-1:0] VA1 = CW'(prpi_pkg::V_START + prpi_pkg::V_ACTIVE);

	if (prpi_pkg::FRAME_CYCLES * prpi_pkg::CLK_PERIOD_NS > prpi_pkg::MAX_FRAME_NS) begin : g_rate
		$error("prpi_ctrl: frame period too long for minimum refresh");
	end

	logic          pclk_r;
	logic [CW-1:0] hcnt_r;
	logic [CW-1:0] vcnt_r;
	logic          fifo_valid;
	logic [PW-1:0] fifo_data;

	// Link outputs other than the scan directions change while the pixel clock falls, so the panel sees them settled at its rise
	wire tick     = pclk_r;
	wire h_end    = (hcnt_r == HT);
	wire active   = (hcnt_r >= HA0) && (hcnt_r < HA1) && (vcnt_r >= VA0) && (vcnt_r < VA1);
	wire pop      = tick & active & fifo_valid;
	wire [PW-1:0] pix_out = pop ? fifo_data : '0;

	prpi_fifo #(.W(PW), .DEPTH(DEPTH)) prpi_fifo_i (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (pix_in_valid),
		.in_ready  (pix_in_ready),
		.in_data   (pix_in_data),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data)
	);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pclk_r                   <= 1'b0;
			hcnt_r                   <= prpi_pkg::CNT_ZERO;
			vcnt_r                   <= prpi_pkg::CNT_ZERO;
			link.pixel_sample_clock  <= 1'b0;
			link.hsync_n             <= 1'b1;
			link.vsync_n             <= 1'b1;
			link.pixel_valid_window  <= 1'b0;
			link.red_component_bus   <= '0;
			link.green_component_bus <= '0;
			link.blue_component_bus  <= '0;
			link.scan_rightward      <= 1'b1;
			link.scan_downward       <= 1'b1;
			frame_tick               <= 1'b0;
			underrun                 <= 1'b0;
		end else begin
			pclk_r                  <= ~pclk_r;
			link.pixel_sample_clock <= ~pclk_r;
			link.scan_rightward     <= ~mirror_h;
			link.scan_downward      <= ~flip_v;
			frame_tick              <= tick & h_end & (vcnt_r == VT);
			underrun                <= tick & active & ~fifo_valid;
			if (tick) begin
				hcnt_r                   <= h_end ? prpi_pkg::CNT_ZERO : hcnt_r + 1'b1;
				if (h_end)
					vcnt_r               <= (vcnt_r == VT) ? prpi_pkg::CNT_ZERO : vcnt_r + 1'b1;
				link.hsync_n             <= ~(hcnt_r < HS);
				link.vsync_n             <= ~(vcnt_r < VS);
				link.pixel_valid_window  <= active & use_enable;
				link.red_component_bus   <= pix_out[prpi_pkg::R_LSB +: prpi_pkg::COMP_W];
				link.green_component_bus <= pix_out[prpi_pkg::G_LSB +: prpi_pkg::COMP_W];
				link.blue_component_bus  <= pix_out[prpi_pkg::B_LSB +: prpi_pkg::COMP_W];
			end
		end
	end
endmodule : prpi_ctrl

/* File: tb/prpi_link_properties.sv */
`timescale 1ns/1ps
module prpi_link_properties (
	input wire logic                        clk,
	input wire logic                        sys_rst,
	input wire logic                        pixel_sample_clock,
	input wire logic                        hsync_n,
	input wire logic                        vsync_n,
	input wire logic                        pixel_valid_window,
	input wire logic [prpi_pkg::COMP_W-1:0] red_component_bus,
	input wire logic [prpi_pkg::COMP_W-1:0] green_component_bus,
	input wire logic [prpi_pkg::COMP_W-1:0] blue_component_bus
);
	localparam int LINE_CLK  = prpi_pkg::H_TOTAL * prpi_pkg::PIX_DIV;
	localparam int HSYNC_CLK = prpi_pkg::H_SYNC * prpi_pkg::PIX_DIV;
	localparam int ACT_CLK   = prpi_pkg::H_ACTIVE * prpi_pkg::PIX_DIV;
	localparam int START_CLK = prpi_pkg::H_START * prpi_pkg::PIX_DIV;
	logic [10:0] en_cnt_r;
	logic [10:0] hs_cnt_r;
	logic [10:0] ln_cnt_r;
	logic        hs_prev_r;
	logic        line_seen_r;
	wire         hs_fall = hs_prev_r & ~hsync_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Counters use sampled values so they line up with the sampled-value functions
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_cnt_r    <= 11'h000;
			hs_cnt_r    <= 11'h000;
			ln_cnt_r    <= 11'h000;
			hs_prev_r   <= 1'b1;
			line_seen_r <= 1'b0;
		end else begin
			en_cnt_r    <= pixel_valid_window ? en_cnt_r + 11'h001 : 11'h000;
			hs_cnt_r    <= hsync_n ? 11'h000 : hs_cnt_r + 11'h001;
			ln_cnt_r    <= hs_fall ? 11'h001 : ln_cnt_r + 11'h001;
			hs_prev_r   <= hsync_n;
			line_seen_r <= line_seen_r | hs_fall;
		end
	end

	sequence pclk_rise; $rose(pixel_sample_clock); endsequence
	sequence pclk_fall; $fell(pixel_sample_clock); endsequence

	a_pclk_rise_fall: assert property (pclk_rise |=> pclk_fall)
		else $error("pixel clock high longer than one cycle");
	a_pclk_fall_rise: assert property (pclk_fall |=> pclk_rise)
		else $error("pixel clock low longer than one cycle");
	a_data_on_fall: assert property ($changed({red_component_bus, green_component_bus,
		blue_component_bus}) |-> pclk_fall)
		else $error("colour data changed away from a pixel clock fall");
	a_enable_width: assert property ($fell(pixel_valid_window) |-> en_cnt_r == ACT_CLK)
		else $error("enable window not 640 pixels");
	a_enable_bounded: assert property (en_cnt_r <= ACT_CLK)
		else $error("enable held high too long");
	a_enable_start: assert property ($rose(pixel_valid_window) |-> ln_cnt_r == START_CLK)
		else $error("enable rose at the wrong line position");
	a_hsync_width: assert property ($rose(hsync_n) |-> hs_cnt_r == HSYNC_CLK)
		else $error("line sync pulse width wrong");
	a_line_period: assert property (hs_fall && line_seen_r |-> ln_cnt_r == LINE_CLK)
		else $error("line period wrong");
	a_enable_syncs: assert property (pixel_valid_window |-> hsync_n && vsync_n)
		else $error("enable high during a sync pulse");
	a_frame_on_line: assert property ($fell(vsync_n) |-> hs_fall)
		else $error("frame sync not aligned to a line start");
endmodule : prpi_link_properties

/* File: tb/prpi_bench.sv */
`timescale 1ns/1ps
module prpi_bench;
	localparam int H = prpi_pkg::H_ACTIVE;
	localparam int V = prpi_pkg::V_ACTIVE;
	logic                       clk, sys_rst, pix_in_valid, pix_in_ready;
	logic                       frame_tick, underrun, pix_valid;
	logic                       use_enable = 1'b0;
	logic                       mirror_h   = 1'b0;
	logic                       flip_v     = 1'b0;
	logic                       line_start, frame_start, default_pos, enable_fault;
	logic [prpi_pkg::PIX_W-1:0] pix_in_data, pix_rgb;
	logic [prpi_pkg::X_W-1:0]   pix_x;
	logic [prpi_pkg::Y_W-1:0]   pix_y;
	int                         fails, checks_done, sent, got, cyc, ln, xi, yl, lines;
	bit                         feed, pend, flip, under_seen, frame_seen, tick_seen;

	prpi_link_if prpi_link_if_i ();
	prpi_ctrl prpi_ctrl_i (.clk(clk), .sys_rst(sys_rst), .link(prpi_link_if_i.ctrl),
		.pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready), .pix_in_data(pix_in_data),
		.use_enable(use_enable), .mirror_h(mirror_h), .flip_v(flip_v),
		.frame_tick(frame_tick), .underrun(underrun));
	prpi_panel prpi_panel_i (.clk(clk), .sys_rst(sys_rst), .link(prpi_link_if_i.panel),
		.pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y), .pix_rgb(pix_rgb),
		.line_start(line_start), .frame_start(frame_start), .default_pos(default_pos),
		.enable_fault(enable_fault));
	prpi_link_properties prpi_link_properties_i (.clk(clk), .sys_rst(sys_rst),
		.pixel_sample_clock(prpi_link_if_i.pixel_sample_clock),
		.hsync_n(prpi_link_if_i.hsync_n), .vsync_n(prpi_link_if_i.vsync_n),
		.pixel_valid_window(prpi_link_if_i.pixel_valid_window),
		.red_component_bus(prpi_link_if_i.red_component_bus),
		.green_component_bus(prpi_link_if_i.green_component_bus),
		.blue_component_bus(prpi_link_if_i.blue_component_bus));

	// Distinct value per component so a swapped or reversed field shows up
	function automatic logic [17:0] pat(input int k);
		return {6'(k), 6'(k) ^ 6'h3F, 6'(k >> 6)};
	endfunction : pat

	task automatic check_word(input string what, input logic [17:0] exp, input logic [17:0] seen);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check_word

	task automatic check_bit(input string what, input logic exp, input logic seen);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %b seen %b", what, exp, seen);
		end
	endtask : check_bit

	task automatic conclude();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Ready seen at the falling edge is what the next rising edge acts on
	always @(negedge clk) begin
		if (pend)
			sent++;
		pix_in_valid = feed && (got < 4 * H);
		pix_in_data  = pat(sent);
		pend         = pix_in_valid & (pix_in_ready === 1'b1);
	end

	always @(negedge clk) begin
		if (underrun === 1'b1)
			under_seen = 1'b1;
		if (frame_start === 1'b1)
			frame_seen = 1'b1;
		if (line_start === 1'b1)
			lines++;
		if (frame_tick === 1'b1)
			tick_seen = 1'b1;
		// First line uses the built-in position, then enable-positioned lines follow
		if (pix_valid === 1'b1) begin
			ln   = got / H;
			xi   = got % H;
			yl   = (ln == 0) ? 0 : ln - 1;
			flip = (ln >= 3);
			if (got == 0)
				check_bit("default_pos", 1'b1, default_pos);
			check_word("pix_rgb", (got < sent) ? pat(got) : 18'h0_0000, pix_rgb);
			check_word("pix_x", 18'(flip ? H - 1 - xi : xi), 18'(pix_x));
			check_word("pix_y", 18'(flip ? V - 1 - yl : yl), 18'(pix_y));
			got++;
			if (got == H)
				use_enable = 1'b1;
			if (got == 3 * H) begin
				mirror_h = 1'b1;
				flip_v   = 1'b1;
			end
		end
	end

	// Reaching line 34 and four lines beyond takes about 57000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 75000) begin
			fails++;
			conclude();
		end
	end

	initial begin
		sys_rst     = 1'b1;
		repeat (8) @(negedge clk);
		check_bit("default_pos", 1'b1, default_pos);
		check_bit("pix_in_ready", 1'b0, pix_in_ready);
		sys_rst = 1'b0;
		feed    = 1'b1;
		repeat (200) @(negedge clk);
		check_word("words buffered", 18'(prpi_pkg::FIFO_DEPTH), 18'(sent));
		check_bit("pix_in_ready", 1'b0, pix_in_ready);
		while (got < 4 * H + 16)
			@(negedge clk);
		check_bit("underrun", 1'b1, under_seen);
		check_bit("frame_start", 1'b1, frame_seen);
		check_word("line_start count", 18'(prpi_pkg::V_START + 5), 18'(lines));
		check_bit("frame_tick", 1'b0, tick_seen);
		check_bit("default_pos", 1'b0, default_pos);
		check_bit("enable_fault", 1'b0, enable_fault);
		conclude();
	end
endmodule : prpi_bench
